// *** atc_pkg.sv ***
// constants, field layouts and carriers for the async timer control block
package atc_pkg;
    // register offsets
    localparam logic [7:0] OFS_CTRL_A = 8'hB0;
    localparam logic [7:0] OFS_CTRL_B = 8'hB1;
    localparam logic [7:0] OFS_CNT = 8'hB2;
    localparam logic [7:0] OFS_CMP_A = 8'hB3;
    localparam logic [7:0] OFS_CMP_B = 8'hB4;
    localparam logic [7:0] OFS_ASYNC = 8'hB6;
    localparam logic [7:0] OFS_MASK = 8'h70;
    localparam logic [7:0] OFS_FLAGS = 8'h37;
    // writable and readable bit masks
    localparam logic [7:0] CTRL_A_RW = 8'hF3;
    localparam logic [7:0] CTRL_B_RW = 8'h0F;
    localparam logic [7:0] MASK_RW = 8'h07;
    localparam logic [7:0] RESET8 = 8'h00;
    // bit positions
    localparam int FOC_A = 7;
    localparam int FOC_B = 6;
    localparam int ASY_EXT = 6;
    localparam int ASY_SEL = 5;
    localparam int UB_CNT = 4;
    localparam int UB_CMPA = 3;
    localparam int UB_CMPB = 2;
    localparam int UB_CTLA = 1;
    localparam int UB_CTLB = 0;
    localparam int NUM_UB = 5;
    localparam int EV_CMPB = 2;
    localparam int EV_CMPA = 1;
    localparam int EV_OVF = 0;
    localparam int NUM_EV = 3;
    // counter landmarks
    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] MAX = 8'hFF;
    localparam logic [7:0] ONE8 = 8'h01;
    // prescaler: tap mask per select code, /8 /32 /64 /128 /256 /1024
    localparam int PRE_W = 10;
    localparam logic [PRE_W-1:0] PRE_ONE = 10'h001;
    localparam logic [PRE_W-1:0] PRE_MASK [0:7] = '{10'h000, 10'h000, 10'h007,
        10'h01F, 10'h03F, 10'h07F, 10'h0FF, 10'h3FF};
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    // mode codes
    localparam logic [2:0] WGM_CTC = 3'h2;
    localparam logic [2:0] WGM_FAST_TOPA = 3'h7;
    localparam logic [1:0] WGM_PC_LO = 2'h1;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR = 2'h2;
    localparam logic [1:0] OM_SET = 2'h3;
    typedef struct packed {
        logic [1:0] out_mode_a;
        logic [1:0] out_mode_b;
        logic [1:0] rsv;
        logic [1:0] wave_mode_lo;
    } atc_ctrl_a_s;
    typedef struct packed {
        logic force_compare_a;
        logic force_compare_b;
        logic [1:0] rsv;
        logic wave_mode_top_bit;
        logic [2:0] clock_prescale_sel;
    } atc_ctrl_b_s;
endpackage : atc_pkg

// *** atc_timer.sv ***
// timer/counter core with control, compare, async update and interrupt registers
//
// Implementation choice: the plain strobed port.
module atc_timer (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // interrupt side
    input wire logic GIE,
    input wire logic [2:0] VEC_ACK,
    output logic [2:0] IRQ,
    // oscillator pin and waveform pins
    input wire logic OSC_IN,
    output logic OSC_RUN,
    output logic EXT_CLK_EN,
    output logic WAVE_A,
    output logic WAVE_B
);
    atc_pkg::atc_ctrl_a_s tmp_ca;
    atc_pkg::atc_ctrl_a_s act_ca;
    atc_pkg::atc_ctrl_b_s tmp_cb;
    atc_pkg::atc_ctrl_b_s act_cb;
    logic [7:0] tmp_cnt;
    logic [7:0] tmp_oa;
    logic [7:0] tmp_ob;
    logic [7:0] act_oa;
    logic [7:0] act_ob;
    logic [7:0] cnt;
    logic [7:0] mask;
    logic [atc_pkg::NUM_UB-1:0] busy;
    logic [atc_pkg::NUM_EV-1:0] flags;
    logic ext_en;
    logic asy_sel;
    logic [atc_pkg::PRE_W-1:0] pre;
    logic up;
    logic blk;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;

    // address decode
    wire wr_ca = WR && (ADDR == atc_pkg::OFS_CTRL_A);
    wire wr_cb = WR && (ADDR == atc_pkg::OFS_CTRL_B);
    wire wr_cnt = WR && (ADDR == atc_pkg::OFS_CNT);
    wire wr_oa = WR && (ADDR == atc_pkg::OFS_CMP_A);
    wire wr_ob = WR && (ADDR == atc_pkg::OFS_CMP_B);
    wire wr_as = WR && (ADDR == atc_pkg::OFS_ASYNC);
    wire wr_mk = WR && (ADDR == atc_pkg::OFS_MASK);
    wire wr_fl = WR && (ADDR == atc_pkg::OFS_FLAGS);
    wire [atc_pkg::NUM_UB-1:0] wr_hit = {wr_cnt, wr_oa, wr_ob, wr_ca, wr_cb};

    // timer source select
    // a source switch leaves pending transfers behind; software rewrites them
    wire async = asy_sel;
    // edge of synchronised oscillator, never of the first stage
    wire osc_edge = osc_s2 & ~osc_s3;
    wire src_tick = async ? osc_edge : 1'b1;

    // busy set on async write, cleared on transfer
    wire [atc_pkg::NUM_UB-1:0] xfer;
    wire [atc_pkg::NUM_UB-1:0] next_busy;
    genvar gi;
    generate
        for (gi = 0; gi < atc_pkg::NUM_UB; gi++) begin : g_busy
            // a write in the transfer cycle wins and waits for the next tick
            assign xfer[gi] = async & busy[gi] & src_tick & ~wr_hit[gi];
            // flags stay clear while on the io clock
            assign next_busy[gi] = async & (wr_hit[gi] | (busy[gi] & ~src_tick));
        end
    endgenerate

    wire [2:0] wgm = {act_cb.wave_mode_top_bit, act_ca.wave_mode_lo};
    wire pwm = wgm[0];
    wire pc = (wgm[1:0] == atc_pkg::WGM_PC_LO);
    wire top_is_a = (wgm == atc_pkg::WGM_CTC) | wgm[2];
    wire [7:0] top = top_is_a ? act_oa : atc_pkg::MAX;
    wire at_top = (cnt == top);
    wire at_bot = (cnt == atc_pkg::BOTTOM);

    wire [2:0] cs = act_cb.clock_prescale_sel;
    wire [atc_pkg::PRE_W-1:0] tap = atc_pkg::PRE_MASK[cs];
    wire pre_hit = (cs == atc_pkg::CS_DIV1) | ((pre & tap) == tap);
    wire count_tick = src_tick & (cs != atc_pkg::CS_STOP) & pre_hit;

    wire cnt_load = (~async & wr_cnt) | xfer[atc_pkg::UB_CNT];
    wire [7:0] cnt_load_val = async ? tmp_cnt : WDATA;

    // counting sequence
    // phase correct turns at top and bottom, every other mode wraps to bottom
    logic [7:0] next_cnt;
    logic next_up;
    logic ovf;
    always_comb begin
        next_cnt = cnt;
        next_up = up;
        ovf = 1'b0;
        if (pc) begin
            if (up) begin
                if (at_top) begin
                    next_up = 1'b0;
                    next_cnt = cnt - atc_pkg::ONE8;
                end else begin
                    next_cnt = cnt + atc_pkg::ONE8;
                end
            end else begin
                if (at_bot) begin
                    next_up = 1'b1;
                    next_cnt = cnt + atc_pkg::ONE8;
                    // direction change at bottom in pwm
                    ovf = 1'b1;
                end else begin
                    next_cnt = cnt - atc_pkg::ONE8;
                end
            end
        end else begin
            next_up = 1'b1;
            next_cnt = at_top ? atc_pkg::BOTTOM : cnt + atc_pkg::ONE8;
            // overflow at max, or at top in fast mode with compare A top
            ovf = (wgm == atc_pkg::WGM_FAST_TOPA) ? at_top : (cnt == atc_pkg::MAX);
        end
    end

    // compare A and B matches, masked after a counter write
    wire hit_a = count_tick & (cnt == act_oa) & ~blk;
    wire hit_b = count_tick & (cnt == act_ob) & ~blk;
    wire bottom_evt = count_tick & ~pc & at_top;

    // force A only outside pwm; no flag or counter effect
    wire frc_a = wr_cb & WDATA[atc_pkg::FOC_A] & ~pwm;
    // force B only outside pwm; no flag or counter effect
    wire frc_b = wr_cb & WDATA[atc_pkg::FOC_B] & ~pwm;

    // waveform action shared by both channels
    function automatic logic wave_next(input logic cur, input logic [1:0] om,
        input logic hit, input logic frc, input logic bot, input logic dir,
        input logic is_pwm, input logic is_pc, input logic tgl_ok);
        logic res;
        res = cur;
        if (!is_pwm) begin
            if (hit | frc) begin
                case (om)
                    atc_pkg::OM_TOGGLE: res = ~cur;
                    atc_pkg::OM_CLEAR: res = 1'b0;
                    atc_pkg::OM_SET: res = 1'b1;
                    default: res = cur;
                endcase
            end
        end else begin
            case (om)
                atc_pkg::OM_TOGGLE: res = (hit & tgl_ok) ? ~cur : cur;
                atc_pkg::OM_CLEAR: begin
                    if (is_pc) begin
                        res = hit ? ~dir : cur;
                    end else begin
                        res = hit ? 1'b0 : (bot ? 1'b1 : cur);
                    end
                end
                atc_pkg::OM_SET: begin
                    if (is_pc) begin
                        res = hit ? dir : cur;
                    end else begin
                        res = hit ? 1'b1 : (bot ? 1'b0 : cur);
                    end
                end
                default: res = cur;
            endcase
        end
        return res;
    endfunction : wave_next

    // toggle in pwm only for channel A with compare A as top
    wire next_wa = wave_next(WAVE_A, act_ca.out_mode_a, hit_a, frc_a, bottom_evt,
        up, pwm, pc, wgm[2]);
    wire next_wb = wave_next(WAVE_B, act_ca.out_mode_b, hit_b, frc_b, bottom_evt,
        up, pwm, pc, 1'b0);

    // event flags, set wins over clear
    wire [atc_pkg::NUM_EV-1:0] ev_set = {hit_b, hit_a, count_tick & ovf};
    wire [atc_pkg::NUM_EV-1:0] next_flags;
    wire [atc_pkg::NUM_EV-1:0] next_irq;
    generate
        for (gi = 0; gi < atc_pkg::NUM_EV; gi++) begin : g_flag
            assign next_flags[gi] = ev_set[gi]
                | (flags[gi] & ~((wr_fl & WDATA[gi]) | VEC_ACK[gi]));
            // request needs enable, global enable and flag
            assign next_irq[gi] = flags[gi] & mask[gi] & GIE;
        end
    endgenerate

    // read selection: counter live, control and compare from temporary copies
    wire [7:0] asy_rd = {1'b0, ext_en, asy_sel, busy};
    wire [7:0] rd_val =
        (ADDR == atc_pkg::OFS_CTRL_A) ? (tmp_ca & atc_pkg::CTRL_A_RW) :
        // strobes and reserved bits read zero
        (ADDR == atc_pkg::OFS_CTRL_B) ? (tmp_cb & atc_pkg::CTRL_B_RW) :
        (ADDR == atc_pkg::OFS_CNT) ? cnt :
        (ADDR == atc_pkg::OFS_CMP_A) ? tmp_oa :
        (ADDR == atc_pkg::OFS_CMP_B) ? tmp_ob :
        (ADDR == atc_pkg::OFS_ASYNC) ? asy_rd :
        (ADDR == atc_pkg::OFS_MASK) ? mask :
        (ADDR == atc_pkg::OFS_FLAGS) ? 8'(flags) : atc_pkg::RESET8;

    // oscillator synchroniser
    // pin is taken as synchronous, yet two stages keep a slow edge from
    // reaching the counter as a runt level; costs three cycles per tick
    always_ff @(posedge MCLK) begin
        if (RST) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end else begin
            osc_s1 <= OSC_IN;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    // temporary control copies, only stored bits kept
    always_ff @(posedge MCLK) begin
        if (RST) begin
            tmp_ca <= atc_pkg::RESET8;
            tmp_cb <= atc_pkg::RESET8;
        end else begin
            if (wr_ca) tmp_ca <= WDATA & atc_pkg::CTRL_A_RW;
            if (wr_cb) tmp_cb <= WDATA & atc_pkg::CTRL_B_RW;
        end
    end

    // temporary data copies; the compare copies read back while a transfer waits
    always_ff @(posedge MCLK) begin
        if (RST) begin
            tmp_cnt <= atc_pkg::RESET8;
            tmp_oa <= atc_pkg::RESET8;
            tmp_ob <= atc_pkg::RESET8;
        end else begin
            if (wr_cnt) tmp_cnt <= WDATA;
            if (wr_oa) tmp_oa <= WDATA;
            if (wr_ob) tmp_ob <= WDATA;
        end
    end

    // active control: direct on io clock, by transfer when async
    always_ff @(posedge MCLK) begin
        if (RST) begin
            act_ca <= atc_pkg::RESET8;
            act_cb <= atc_pkg::RESET8;
        end else begin
            if (~async & wr_ca) act_ca <= WDATA & atc_pkg::CTRL_A_RW;
            else if (xfer[atc_pkg::UB_CTLA]) act_ca <= tmp_ca;
            if (~async & wr_cb) act_cb <= WDATA & atc_pkg::CTRL_B_RW;
            else if (xfer[atc_pkg::UB_CTLB]) act_cb <= tmp_cb;
        end
    end

    // active compare values, same update path
    always_ff @(posedge MCLK) begin
        if (RST) begin
            act_oa <= atc_pkg::RESET8;
            act_ob <= atc_pkg::RESET8;
        end else begin
            if (~async & wr_oa) act_oa <= WDATA;
            else if (xfer[atc_pkg::UB_CMPA]) act_oa <= tmp_oa;
            if (~async & wr_ob) act_ob <= WDATA;
            else if (xfer[atc_pkg::UB_CMPB]) act_ob <= tmp_ob;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ext_en <= 1'b0;
            asy_sel <= 1'b0;
        end else if (wr_as) begin
            ext_en <= WDATA[atc_pkg::ASY_EXT];
            asy_sel <= WDATA[atc_pkg::ASY_SEL];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            mask <= atc_pkg::RESET8;
        end else if (wr_mk) begin
            mask <= WDATA & atc_pkg::MASK_RW;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            busy <= '0;
        end else begin
            busy <= next_busy;
        end
    end

    // pin enables follow the select one cycle late
    always_ff @(posedge MCLK) begin
        if (RST) begin
            OSC_RUN <= 1'b0;
            EXT_CLK_EN <= 1'b0;
        end else begin
            // crystal runs only without the external buffer
            OSC_RUN <= asy_sel & ~ext_en;
            EXT_CLK_EN <= asy_sel & ext_en;
        end
    end

    // prescaler free-runs on source ticks and is shared by all taps,
    // so a newly chosen divider may land mid-period on its first count
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pre <= '0;
        end else if (src_tick) begin
            pre <= pre + atc_pkg::PRE_ONE;
        end
    end

    // counter and compare block
    always_ff @(posedge MCLK) begin
        if (RST) begin
            cnt <= atc_pkg::RESET8;
            up <= 1'b1;
            blk <= 1'b0;
        end else begin
            if (cnt_load) begin
                cnt <= cnt_load_val;
                blk <= 1'b1;
            end else if (count_tick) begin
                cnt <= next_cnt;
                up <= next_up;
                blk <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            flags <= '0;
            IRQ <= '0;
        end else begin
            flags <= next_flags;
            IRQ <= next_irq;
        end
    end

    // waveform pins
    always_ff @(posedge MCLK) begin
        if (RST) begin
            WAVE_A <= 1'b0;
            WAVE_B <= 1'b0;
        end else begin
            WAVE_A <= next_wa;
            WAVE_B <= next_wb;
        end
    end

    // read data stands one cycle, zero otherwise
    always_ff @(posedge MCLK) begin
        if (RST) begin
            RDATA <= atc_pkg::RESET8;
        end else begin
            RDATA <= RD ? rd_val : atc_pkg::RESET8;
        end
    end
endmodule : atc_timer

// *** atc_timer_chk.sv ***
// port-level assertions for the async timer control block
module atc_timer_chk (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // interrupts and pins
    input wire logic GIE,
    input wire logic [2:0] IRQ,
    input wire logic OSC_RUN,
    input wire logic EXT_CLK_EN,
    input wire logic WAVE_A
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    rdata_slot_a: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside its slot");
    ctrlb_zero_a: assert property ($past(RD) && $past(ADDR) == atc_pkg::OFS_CTRL_B
        |-> RDATA[7:4] == 4'h0) else $error("force or reserved bits read nonzero");
    irq_b_gate_a: assert property (!GIE |=> !IRQ[2])
        else $error("compare b request without global enable");
    irq_a_gate_a: assert property (!GIE |=> !IRQ[1])
        else $error("compare a request without global enable");
    irq_ovf_gate_a: assert property (!GIE |=> !IRQ[0])
        else $error("overflow request without global enable");
    clk_pin_excl_a: assert property (!(OSC_RUN && EXT_CLK_EN))
        else $error("crystal runs beside external clock buffer");
    clk_sel_cause_a: assert property ($changed(OSC_RUN) || $changed(EXT_CLK_EN)
        |-> $past(WR) || $past(WR, 2)) else $error("clock source moved without a write");
    busy_sync_zero_a: assert property ($past(RD) && $past(ADDR) == atc_pkg::OFS_ASYNC
        && !$past(OSC_RUN) && !$past(EXT_CLK_EN) && !$past(OSC_RUN, 2)
        && !$past(EXT_CLK_EN, 2) |-> RDATA[4:0] == 5'h00) else $error("busy in sync mode");

    cover property ($past(RD) && $past(ADDR) == atc_pkg::OFS_ASYNC && RDATA[2]);
    cover property (IRQ[1]);
    cover property ($rose(WAVE_A));
    cover property (EXT_CLK_EN);
endmodule : atc_timer_chk

bind atc_timer atc_timer_chk i_chk (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WR(WR),
    .RD(RD), .RDATA(RDATA), .GIE(GIE), .IRQ(IRQ), .OSC_RUN(OSC_RUN),
    .EXT_CLK_EN(EXT_CLK_EN), .WAVE_A(WAVE_A));

// *** atc_timer_test.sv ***
// self-checking bench for the async timer control block
module atc_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wstb = 1'b0;
    logic rstb = 1'b0;
    logic gie = 1'b0;
    logic [2:0] vec_ack = 3'h0;
    logic osc_in = 1'b0;
    logic [7:0] rdata;
    logic [2:0] irq;
    logic osc_run;
    logic ext_clk_en;
    logic wave_a;
    logic wave_b;
    int err_total = 0;
    int total_checks = 0;
    int divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};

    atc_timer i_dut (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wstb),
        .RD(rstb), .RDATA(rdata), .GIE(gie), .VEC_ACK(vec_ack), .IRQ(irq),
        .OSC_IN(osc_in), .OSC_RUN(osc_run), .EXT_CLK_EN(ext_clk_en),
        .WAVE_A(wave_a), .WAVE_B(wave_b));

    always #20 mclk = ~mclk;

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk8

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wstb <= 1'b1;
        @(posedge mclk);
        wstb <= 1'b0;
    endtask : reg_wr

    // data is registered, so it is taken just after the edge ending the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge mclk);
        rstb <= 1'b0;
        #1;
        chk8(rdata, exp, what);
    endtask : rd_chk

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle

    task automatic done(input string n);
        $display("test %s finished", n);
    endtask : done

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        idle(20000);
        err_total++;
        print_verdict();
    end

    initial begin
        idle(2);
        rst <= 1'b0;
        rd_chk(atc_pkg::OFS_CTRL_B, 8'h00, "ctrl b reset");
        rd_chk(atc_pkg::OFS_ASYNC, 8'h00, "async reset");
        rd_chk(atc_pkg::OFS_CNT, 8'h00, "count reset");
        chk8({1'b0, irq, osc_run, ext_clk_en, wave_a, wave_b}, 8'h00, "pins reset");
        done("reset");
        reg_wr(atc_pkg::OFS_CTRL_B, 8'hFF);
        rd_chk(atc_pkg::OFS_CTRL_B, 8'h0F, "ctrl b layout");
        reg_wr(atc_pkg::OFS_CTRL_B, 8'h00);
        reg_wr(8'hB5, 8'hA5);
        rd_chk(8'hB5, 8'h00, "unmapped");
        reg_wr(atc_pkg::OFS_CNT, 8'h5A);
        rd_chk(atc_pkg::OFS_CNT, 8'h5A, "counter");
        reg_wr(atc_pkg::OFS_CMP_A, 8'hC3);
        rd_chk(atc_pkg::OFS_CMP_A, 8'hC3, "compare a");
        reg_wr(atc_pkg::OFS_CMP_B, 8'h3C);
        rd_chk(atc_pkg::OFS_CMP_B, 8'h3C, "compare b");
        done("registers");
        // the run spans exactly four periods of each divided clock
        for (int i = 1; i < 8; i++) begin
            reg_wr(atc_pkg::OFS_CNT, 8'h00);
            reg_wr(atc_pkg::OFS_CTRL_B, 8'(i));
            idle(4 * divs[i] - 2);
            reg_wr(atc_pkg::OFS_CTRL_B, 8'h00);
            rd_chk(atc_pkg::OFS_CNT, 8'h04, "prescaled count");
        end
        done("prescaler");
        reg_wr(atc_pkg::OFS_CTRL_A, 8'h70);
        reg_wr(atc_pkg::OFS_CMP_A, 8'h05);
        reg_wr(atc_pkg::OFS_CMP_B, 8'h80);
        reg_wr(atc_pkg::OFS_CNT, 8'h00);
        reg_wr(atc_pkg::OFS_FLAGS, 8'h07);
        reg_wr(atc_pkg::OFS_MASK, 8'h02);
        gie <= 1'b1;
        reg_wr(atc_pkg::OFS_CTRL_B, 8'h01);
        idle(12);
        reg_wr(atc_pkg::OFS_CTRL_B, 8'h00);
        chk8({5'h00, irq}, 8'h02, "compare a request");
        chk8({7'h00, wave_a}, 8'h01, "toggle on match");
        rd_chk(atc_pkg::OFS_FLAGS, 8'h02, "compare a flag");
        gie <= 1'b0;
        idle(2);
        chk8({5'h00, irq}, 8'h00, "global gate");
        gie <= 1'b1;
        vec_ack <= 3'h2;
        idle(1);
        vec_ack <= 3'h0;
        idle(2);
        chk8({5'h00, irq}, 8'h00, "vector clear");
        rd_chk(atc_pkg::OFS_FLAGS, 8'h00, "flag cleared");
        done("compare a");
        reg_wr(atc_pkg::OFS_CTRL_A, 8'h72);
        reg_wr(atc_pkg::OFS_CNT, 8'h20);
        reg_wr(atc_pkg::OFS_CTRL_B, 8'h80);
        idle(2);
        chk8({7'h00, wave_a}, 8'h00, "force a toggles");
        rd_chk(atc_pkg::OFS_CNT, 8'h20, "force keeps count");
        reg_wr(atc_pkg::OFS_CTRL_B, 8'h40);
        idle(2);
        chk8({7'h00, wave_b}, 8'h01, "force b sets");
        rd_chk(atc_pkg::OFS_FLAGS, 8'h00, "force raises no flag");
        reg_wr(atc_pkg::OFS_CTRL_A, 8'hC3);
        reg_wr(atc_pkg::OFS_CTRL_B, 8'h80);
        idle(2);
        chk8({7'h00, wave_a}, 8'h00, "force ignored in pwm");
        reg_wr(atc_pkg::OFS_CTRL_B, 8'h00);
        done("force");
        reg_wr(atc_pkg::OFS_CTRL_A, 8'h00);
        reg_wr(atc_pkg::OFS_CMP_A, 8'h10);
        reg_wr(atc_pkg::OFS_CNT, 8'h10);
        reg_wr(atc_pkg::OFS_FLAGS, 8'h07);
        reg_wr(atc_pkg::OFS_CTRL_B, 8'h01);
        idle(3);
        reg_wr(atc_pkg::OFS_CTRL_B, 8'h00);
        rd_chk(atc_pkg::OFS_FLAGS, 8'h00, "match blocked after write");
        reg_wr(atc_pkg::OFS_MASK, 8'h05);
        reg_wr(atc_pkg::OFS_CMP_B, 8'hFE);
        reg_wr(atc_pkg::OFS_CNT, 8'hFC);
        reg_wr(atc_pkg::OFS_CTRL_B, 8'h01);
        idle(8);
        reg_wr(atc_pkg::OFS_CTRL_B, 8'h00);
        chk8({5'h00, irq}, 8'h05, "overflow and b requests");
        rd_chk(atc_pkg::OFS_FLAGS, 8'h05, "overflow and b flags");
        reg_wr(atc_pkg::OFS_FLAGS, 8'h05);
        idle(2);
        chk8({5'h00, irq}, 8'h00, "write one clears");
        reg_wr(atc_pkg::OFS_CTRL_A, 8'h02);
        reg_wr(atc_pkg::OFS_CMP_A, 8'h03);
        reg_wr(atc_pkg::OFS_CNT, 8'h00);
        reg_wr(atc_pkg::OFS_CTRL_B, 8'h01);
        idle(8);
        reg_wr(atc_pkg::OFS_CTRL_B, 8'h00);
        rd_chk(atc_pkg::OFS_CNT, 8'h02, "ctc wraps at compare a");
        rd_chk(atc_pkg::OFS_FLAGS, 8'h02, "ctc compare a flag");
        done("overflow");
        // external enable goes first so the crystal never starts
        reg_wr(atc_pkg::OFS_ASYNC, 8'h40);
        reg_wr(atc_pkg::OFS_ASYNC, 8'h60);
        idle(2);
        chk8({6'h00, osc_run, ext_clk_en}, 8'h01, "external buffer");
        reg_wr(atc_pkg::OFS_CMP_B, 8'h33);
        rd_chk(atc_pkg::OFS_ASYNC, 8'h64, "busy set");
        rd_chk(atc_pkg::OFS_CMP_B, 8'h33, "temporary value");
        repeat (4) begin
            osc_in <= ~osc_in;
            idle(4);
        end
        rd_chk(atc_pkg::OFS_ASYNC, 8'h60, "busy cleared");
        reg_wr(atc_pkg::OFS_ASYNC, 8'h20);
        idle(2);
        chk8({6'h00, osc_run, ext_clk_en}, 8'h02, "crystal runs");
        reg_wr(atc_pkg::OFS_ASYNC, 8'h00);
        reg_wr(atc_pkg::OFS_CMP_A, 8'h44);
        rd_chk(atc_pkg::OFS_ASYNC, 8'h00, "no busy in sync");
        done("async");
        print_verdict();
    end
endmodule : atc_timer_test
